// ===== rtl/exc_pkg.sv
// exception event codes, event kinds and priority levels
// assumes: shared by the acceptance unit and its two encoders
package exc_pkg;

	// ------------------------------------------------------------
	// event code field
	// ------------------------------------------------------------
	localparam int CODE_W = 12;
	localparam int CODE_MSB = 11;
	localparam int CODE_LSB = 0;

	// ------------------------------------------------------------
	// event codes
	// ------------------------------------------------------------
	localparam logic [11:0] CODE_POR       = 12'h000;
	localparam logic [11:0] CODE_MRST      = 12'h020;
	localparam logic [11:0] CODE_DBG_RST   = 12'h000;
	localparam logic [11:0] CODE_TLB_R     = 12'h040;
	localparam logic [11:0] CODE_TLB_W     = 12'h060;
	localparam logic [11:0] CODE_RPT_MISS  = 12'h070;
	localparam logic [11:0] CODE_IPW       = 12'h080;
	localparam logic [11:0] CODE_PROT_R    = 12'h0A0;
	localparam logic [11:0] CODE_PROT_W    = 12'h0C0;
	localparam logic [11:0] CODE_PROT_RPT  = 12'h0D0;
	localparam logic [11:0] CODE_AERR_R    = 12'h0E0;
	localparam logic [11:0] CODE_AERR_W    = 12'h100;
	localparam logic [11:0] CODE_TRAP      = 12'h160;
	localparam logic [11:0] CODE_ILLEGAL   = 12'h180;
	localparam logic [11:0] CODE_SLOT_ILL  = 12'h1A0;
	localparam logic [11:0] CODE_NMI       = 12'h1C0;
	localparam logic [11:0] CODE_UBRK      = 12'h1E0;
	localparam logic [11:0] CODE_EXT_BASE  = 12'h200;
	localparam logic [11:0] CODE_DMA_AERR  = 12'h5C0;
	localparam logic [11:0] CODE_DBG_IRQ   = 12'h5E0;
	localparam int          EXT_STEP_SHIFT = 5;

	// ------------------------------------------------------------
	// general event kinds, index = execution order rank
	// ------------------------------------------------------------
	localparam int KI_UBRK_PRE  = 0;
	localparam int KI_IADDR     = 1;
	localparam int KI_ITLB_MISS = 2;
	localparam int KI_ITLB_INV  = 3;
	localparam int KI_ITLB_PROT = 4;
	localparam int KI_ILLEGAL   = 5;
	localparam int KI_SLOT_ILL  = 6;
	localparam int KI_TRAP      = 7;
	localparam int KI_DADDR     = 8;
	localparam int KI_DTLB_MISS = 9;
	localparam int KI_DTLB_INV  = 10;
	localparam int KI_DTLB_PROT = 11;
	localparam int KI_IPW       = 12;
	localparam int KI_UBRK_POST = 13;
	localparam int KI_DMA       = 14;
	localparam int N_KIND       = 15;
	// kinds that abort and re-execute the instruction
	localparam logic [14:0] REEXEC_MASK = 15'h1F7E;

	// ------------------------------------------------------------
	// acceptance levels, 1 highest
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LVL_NONE    = 3'h0,
		LVL_RESET   = 3'h1,
		LVL_GENERAL = 3'h2,
		LVL_NMI     = 3'h3,
		LVL_IRQ     = 3'h4
	} level_t;

endpackage

// ===== rtl/gen_exc_select.sv
// picks the first event in execution order of one instruction and codes it
// assumes: purely combinational, fed from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module gen_exc_select (
	// events detected for one instruction
	input  wire logic [14:0] exc,
	input  wire logic        wr,
	input  wire logic        rpt,
	// chosen event
	output logic             valid,
	output logic [11:0]      code,
	output logic             reexec
);

	// instruction fetches are reads, so only data kinds look at wr
	function automatic logic [11:0] kind_code(input int k, input logic w, input logic r);
		logic dw;
		dw = w && (k >= exc_pkg::KI_DADDR);
		case (k)
			exc_pkg::KI_IADDR, exc_pkg::KI_DADDR:
				kind_code = r ? exc_pkg::CODE_RPT_MISS : (dw ? exc_pkg::CODE_AERR_W : exc_pkg::CODE_AERR_R);
			exc_pkg::KI_ITLB_MISS, exc_pkg::KI_ITLB_INV, exc_pkg::KI_DTLB_MISS, exc_pkg::KI_DTLB_INV:
				kind_code = r ? exc_pkg::CODE_RPT_MISS : (dw ? exc_pkg::CODE_TLB_W : exc_pkg::CODE_TLB_R);
			exc_pkg::KI_ITLB_PROT, exc_pkg::KI_DTLB_PROT:
				kind_code = r ? exc_pkg::CODE_PROT_RPT : (dw ? exc_pkg::CODE_PROT_W : exc_pkg::CODE_PROT_R);
			exc_pkg::KI_IPW:       kind_code = exc_pkg::CODE_IPW;
			// decode-stage kinds never coincide, so ranks 5 to 7 act as one rank
			exc_pkg::KI_ILLEGAL:   kind_code = exc_pkg::CODE_ILLEGAL;
			exc_pkg::KI_SLOT_ILL:  kind_code = exc_pkg::CODE_SLOT_ILL;
			exc_pkg::KI_TRAP:      kind_code = exc_pkg::CODE_TRAP;
			exc_pkg::KI_UBRK_PRE,
			exc_pkg::KI_UBRK_POST: kind_code = exc_pkg::CODE_UBRK;
			default:               kind_code = exc_pkg::CODE_DMA_AERR;
		endcase
	endfunction

	// lowest rank wins; scanning downward lets it overwrite later ranks
	always_comb begin
		valid = 1'b0;
		code = exc_pkg::CODE_POR;
		reexec = 1'b0;
		for (int k = exc_pkg::N_KIND - 1; k >= 0; k--) begin
			if (exc[k]) begin
				valid = 1'b1;
				code = kind_code(k, wr, rpt);
				reexec = exc_pkg::REEXEC_MASK[k];
			end
		end
	end

endmodule // gen_exc_select
`default_nettype wire

// ===== rtl/irq_code_enc.sv
// ranks pending interrupts and forms their event code
// assumes: requests come from the interrupt controller on the core clock
`timescale 1ns/10ps
`default_nettype none
module irq_code_enc (
	// pending requests
	input  wire logic       nmi,
	input  wire logic       dbg_irq,
	input  wire logic       ext_irq,
	input  wire logic [3:0] level,
	input  wire logic       dbg_first,
	// chosen request
	output logic            valid,
	output logic            is_nmi,
	output logic [11:0]     code
);

	// nmi outranks level 4; order inside level 4 is set by software
	always_comb begin
		valid = nmi | dbg_irq | ext_irq;
		is_nmi = nmi;
		if (nmi) begin
			code = exc_pkg::CODE_NMI;
		end else if (dbg_irq && (dbg_first || !ext_irq)) begin
			code = exc_pkg::CODE_DBG_IRQ;
		end else begin
			code = exc_pkg::CODE_EXT_BASE + {3'h0, level, 5'h00};
		end
	end

endmodule // irq_code_enc
`default_nettype wire

// ===== rtl/exception_priority_code_unit.sv
// exception acceptance and event coding for the core
// assumes: pipeline and interrupt controller on mclk; reset pins asynchronous
`timescale 1ns/10ps
`default_nettype none
module exception_priority_code_unit (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// reset requests from pins
	input  wire logic             por_req,
	input  wire logic             manual_reset_req,
	input  wire logic             dbg_reset_req,
	// pipeline
	input  wire logic             boundary,
	input  wire logic             mem_busy,
	input  wire logic             block_mask,
	input  wire logic             id_delayed_uncond,
	input  wire logic             id_delayed_cond,
	input  wire logic             branch_taken,
	input  wire logic [14:0]      older_exc,
	input  wire logic             older_wr,
	input  wire logic             older_rpt,
	input  wire logic [14:0]      younger_exc,
	input  wire logic             younger_wr,
	input  wire logic             younger_rpt,
	// interrupt controller
	input  wire logic             nmi_req,
	input  wire logic             user_debug_interface_irq,
	input  wire logic             ext_irq_req,
	input  wire logic [3:0]       external_interrupt_level,
	input  wire logic             dbg_over_ext,
	// event registers and acceptance
	output logic [11:0]           exception_event_reg,
	output logic [11:0]           interrupt_event_reg,
	output logic [11:0]           interrupt_event_reg_alt,
	output logic                  accept,
	output exc_pkg::level_t       accept_level,
	output logic                  retry_from_branch,
	output logic                  reset_taken
);

	// ------------------------------------------------------------
	// reset pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic       por_s;
	logic       mrst_s;
	logic       dbg_s;

	// first stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else begin
			pin_s1 <= {dbg_reset_req, manual_reset_req, por_req};
			pin_s2 <= pin_s1;
		end
	end

	assign por_s = pin_s2[0];
	assign mrst_s = pin_s2[1];
	assign dbg_s = pin_s2[2];

	// ------------------------------------------------------------
	// event selection
	// ------------------------------------------------------------
	logic        old_valid;
	logic [11:0] old_code;
	logic        old_reexec;
	logic        yng_valid;
	logic [11:0] yng_code;
	logic        yng_reexec;
	logic        int_valid;
	logic        int_nmi;
	logic [11:0] int_code;

	gen_exc_select u_older (
		.exc    (older_exc),
		.wr     (older_wr),
		.rpt    (older_rpt),
		.valid  (old_valid),
		.code   (old_code),
		.reexec (old_reexec)
	);

	gen_exc_select u_younger (
		.exc    (younger_exc),
		.wr     (younger_wr),
		.rpt    (younger_rpt),
		.valid  (yng_valid),
		.code   (yng_code),
		.reexec (yng_reexec)
	);

	irq_code_enc u_irq (
		.nmi       (nmi_req),
		.dbg_irq   (user_debug_interface_irq),
		.ext_irq   (ext_irq_req),
		.level     (external_interrupt_level),
		.dbg_first (dbg_over_ext),
		.valid     (int_valid),
		.is_nmi    (int_nmi),
		.code      (int_code)
	);

	// ------------------------------------------------------------
	// acceptance conditions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_SLOT = 2'b01,
		ST_MRST = 2'b10
	} st_t;

	st_t         state;
	logic        hard_rst;
	logic        run_bnd;
	logic        slot_bnd;
	logic        br_taken;
	logic        gen_valid;
	logic [11:0] gen_code;
	logic        take_gen;
	logic        take_slot;
	logic        take_int;

	assign hard_rst = por_s | dbg_s;
	assign run_bnd = boundary && (state == ST_RUN) && !hard_rst && !mrst_s;
	assign slot_bnd = boundary && (state == ST_SLOT) && !hard_rst && !mrst_s;
	assign br_taken = id_delayed_uncond | (id_delayed_cond & branch_taken);
	assign gen_valid = old_valid | yng_valid;
	assign gen_code = old_valid ? old_code : yng_code;
	assign take_gen = run_bnd && gen_valid;
	// only a re-executing slot event leaves before the branch runs
	assign take_slot = slot_bnd && !old_valid && yng_valid && yng_reexec;
	// interrupts held pending while blocked; nmi ranks over level 4
	assign take_int = run_bnd && !gen_valid && int_valid && !block_mask;

	// ------------------------------------------------------------
	// next state and event registers
	// ------------------------------------------------------------
	st_t             next_state;
	logic [11:0]     next_exp;
	logic [11:0]     next_int;
	logic [11:0]     next_int_alt;
	logic            next_accept;
	exc_pkg::level_t next_level;
	logic            next_retry;
	logic            next_rst_taken;

	// resets outrank everything and ignore boundaries
	always_comb begin
		next_state = state;
		next_exp = exception_event_reg;
		next_int = interrupt_event_reg;
		next_int_alt = interrupt_event_reg_alt;
		next_accept = 1'b0;
		next_level = exc_pkg::LVL_NONE;
		next_retry = 1'b0;
		next_rst_taken = 1'b0;
		if (hard_rst) begin
			next_state = ST_RUN;
			next_exp = por_s ? exc_pkg::CODE_POR : exc_pkg::CODE_DBG_RST;
			next_accept = 1'b1;
			next_level = exc_pkg::LVL_RESET;
			next_rst_taken = 1'b1;
		end else begin
			unique case (state)
				ST_MRST: begin
					// manual reset waits for the memory access in flight
					if (!mem_busy) begin
						next_state = ST_RUN;
						next_exp = exc_pkg::CODE_MRST;
						next_accept = 1'b1;
						next_level = exc_pkg::LVL_RESET;
						next_rst_taken = 1'b1;
					end
				end
				ST_RUN, ST_SLOT: begin
					if (mrst_s) begin
						next_state = ST_MRST;
					end else if (take_gen || take_slot) begin
						next_state = ST_RUN;
						next_exp = take_gen ? gen_code : yng_code;
						next_accept = 1'b1;
						next_level = exc_pkg::LVL_GENERAL;
						next_retry = take_slot;
					end else if (take_int) begin
						next_int = int_code;
						next_int_alt = int_code;
						next_accept = 1'b1;
						next_level = int_nmi ? exc_pkg::LVL_NMI : exc_pkg::LVL_IRQ;
					end else if (slot_bnd) begin
						next_state = ST_RUN;
					end else if (run_bnd && br_taken) begin
						next_state = ST_SLOT;
					end
				end
				default: begin
					next_state = ST_RUN;
				end
			endcase
		end
	end

	// registers only; reset shows power-on code
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_RUN;
			exception_event_reg <= exc_pkg::CODE_POR;
			interrupt_event_reg <= exc_pkg::CODE_POR;
			interrupt_event_reg_alt <= exc_pkg::CODE_POR;
			accept <= 1'b0;
			accept_level <= exc_pkg::LVL_NONE;
			retry_from_branch <= 1'b0;
			reset_taken <= 1'b0;
		end else begin
			state <= next_state;
			exception_event_reg <= next_exp;
			interrupt_event_reg <= next_int;
			interrupt_event_reg_alt <= next_int_alt;
			accept <= next_accept;
			accept_level <= next_level;
			retry_from_branch <= next_retry;
			reset_taken <= next_rst_taken;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_LEVEL_RANGE: assert property (
		accept |-> (accept_level >= exc_pkg::LVL_RESET) && (accept_level <= exc_pkg::LVL_IRQ)
	) else $error("accepted event has no valid level");

	AST_HARD_RESET: assert property (
		hard_rst |=> accept && reset_taken && (accept_level == exc_pkg::LVL_RESET)
	) else $error("reset request not taken next cycle");

	AST_RESET_CODE: assert property (
		(state == ST_MRST && !mem_busy && !hard_rst) |=> exception_event_reg == exc_pkg::CODE_MRST
	) else $error("manual reset code wrong");

	AST_PROG_ORDER: assert property (
		(run_bnd && old_valid && yng_valid) |=> exception_event_reg == $past(old_code)
	) else $error("younger instruction taken before older");

	AST_BOUNDARY_ONLY: assert property (
		(accept && !reset_taken) |-> $past(boundary)
	) else $error("exception taken off a boundary");

	AST_SLOT_BLOCK: assert property (
		(state == ST_SLOT && boundary && !take_slot) |=> !accept || reset_taken
	) else $error("event taken between branch and slot");

	AST_SLOT_RETRY: assert property (
		take_slot |=> accept && retry_from_branch && (accept_level == exc_pkg::LVL_GENERAL)
	) else $error("slot re-execution not taken before branch");

	AST_SLOT_ENTRY: assert property (
		(run_bnd && br_taken && !gen_valid && !take_int) |=> state == ST_SLOT
	) else $error("taken delayed branch did not open slot");

	AST_INT_BOTH: assert property (
		(accept && accept_level >= exc_pkg::LVL_NMI) |-> interrupt_event_reg == interrupt_event_reg_alt
	) else $error("interrupt registers disagree");

	AST_NMI_CODE: assert property (
		(take_int && nmi_req) |=> accept && (accept_level == exc_pkg::LVL_NMI)
			&& (interrupt_event_reg == exc_pkg::CODE_NMI)
	) else $error("nmi code wrong");

	AST_EXT_CODE: assert property (
		(take_int && !nmi_req && ext_irq_req && !user_debug_interface_irq)
		|=> interrupt_event_reg == exc_pkg::CODE_EXT_BASE + {3'h0, $past(external_interrupt_level), 5'h00}
	) else $error("external level code wrong");

	COV_MRST: cover property (state == ST_MRST ##[1:20] reset_taken);
	COV_SLOT_RETRY: cover property (accept && retry_from_branch);
	COV_NMI: cover property (accept && accept_level == exc_pkg::LVL_NMI);
	COV_ORDER: cover property (run_bnd && old_valid && yng_valid);

endmodule // exception_priority_code_unit
`default_nettype wire

// ===== tb/irq_ctrl_model.sv
// interrupt controller model facing the exception unit
// assumes: one mclk domain; the bench raises requests with one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_model (
	// clock and reset
	input  wire logic            mclk,
	input  wire logic            rst,
	// requests raised by the bench
	input  wire logic            raise_nmi,
	input  wire logic            raise_dbg,
	input  wire logic            raise_ext,
	input  wire logic [3:0]      raise_level,
	// acceptance seen from the unit
	input  wire logic            accept,
	input  wire exc_pkg::level_t accept_level,
	input  wire logic [11:0]     int_code,
	// request lines to the unit
	output logic                 nmi_req,
	output logic                 dbg_irq,
	output logic                 ext_irq,
	output logic [3:0]           ext_level
);

	logic [3:0] held_level;
	logic       next_nmi;
	logic       next_dbg;
	logic       next_ext;
	logic [3:0] next_level;

	// ------------------------------------------------------------
	// pending requests
	// ------------------------------------------------------------
	// a request stays up, unrelated to the instruction stream, until its own acceptance
	always_comb begin
		next_nmi = nmi_req | raise_nmi;
		next_dbg = dbg_irq | raise_dbg;
		next_ext = ext_irq | raise_ext;
		next_level = raise_ext ? raise_level : held_level;
		if (accept && accept_level == exc_pkg::LVL_NMI) begin
			next_nmi = 1'b0;
		end
		// the written code tells which level-4 source was served
		if (accept && accept_level == exc_pkg::LVL_IRQ) begin
			if (int_code == exc_pkg::CODE_DBG_IRQ) begin
				next_dbg = 1'b0;
			end else begin
				next_ext = 1'b0;
			end
		end
	end

	// register only
	always_ff @(posedge mclk) begin
		if (rst) begin
			nmi_req <= 1'b0;
			dbg_irq <= 1'b0;
			ext_irq <= 1'b0;
			held_level <= 4'h0;
		end else begin
			nmi_req <= next_nmi;
			dbg_irq <= next_dbg;
			ext_irq <= next_ext;
			held_level <= next_level;
		end
	end

	// released level lines show the inverted held level, not the last value
	assign ext_level = ext_irq ? held_level : ~held_level;

endmodule // irq_ctrl_model
`default_nettype wire

// ===== tb/exception_priority_code_unit_test.sv
// self-checking bench for the exception priority and code unit
// assumes: irq_ctrl_model stands in for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module exception_priority_code_unit_test;

	typedef struct {logic [14:0] exc; logic wr; logic rpt; logic [11:0] code;} row_t;

	logic            mclk, rst, por_req, manual_reset_req, dbg_reset_req;
	logic            boundary, mem_busy, block_mask, dbg_over_ext;
	logic            id_delayed_uncond, id_delayed_cond, branch_taken;
	logic [14:0]     older_exc, younger_exc;
	logic            older_wr, older_rpt, younger_wr, younger_rpt;
	logic            r_nmi, r_dbg, r_ext;
	logic [3:0]      r_lvl;
	wire logic       nmi_req, udi_irq, ext_irq_req;
	wire logic [3:0] ext_lvl;
	logic [11:0]     exception_event_reg, interrupt_event_reg, interrupt_event_reg_alt;
	logic            accept, retry_from_branch, reset_taken;
	exc_pkg::level_t accept_level;
	row_t            rows [21];
	int              n_fail, tests_run, lv;

	exception_priority_code_unit exception_priority_code_unit_i (.mclk(mclk), .rst(rst),
		.por_req(por_req), .manual_reset_req(manual_reset_req), .dbg_reset_req(dbg_reset_req),
		.boundary(boundary), .mem_busy(mem_busy), .block_mask(block_mask),
		.id_delayed_uncond(id_delayed_uncond), .id_delayed_cond(id_delayed_cond),
		.branch_taken(branch_taken), .older_exc(older_exc), .older_wr(older_wr), .older_rpt(older_rpt),
		.younger_exc(younger_exc), .younger_wr(younger_wr), .younger_rpt(younger_rpt),
		.nmi_req(nmi_req), .user_debug_interface_irq(udi_irq), .ext_irq_req(ext_irq_req),
		.external_interrupt_level(ext_lvl), .dbg_over_ext(dbg_over_ext),
		.exception_event_reg(exception_event_reg), .interrupt_event_reg(interrupt_event_reg),
		.interrupt_event_reg_alt(interrupt_event_reg_alt), .accept(accept),
		.accept_level(accept_level), .retry_from_branch(retry_from_branch), .reset_taken(reset_taken));

	irq_ctrl_model irq_ctrl_model_i (.mclk(mclk), .rst(rst), .raise_nmi(r_nmi), .raise_dbg(r_dbg),
		.raise_ext(r_ext), .raise_level(r_lvl), .accept(accept), .accept_level(accept_level),
		.int_code(interrupt_event_reg), .nmi_req(nmi_req), .dbg_irq(udi_irq), .ext_irq(ext_irq_req),
		.ext_level(ext_lvl));

	// 100 MHz core clock
	always #5 mclk = ~mclk;

	// ------------------------------------------------------------
	// compare and drive tasks
	// ------------------------------------------------------------
	task automatic bad(input string m);
		n_fail++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) bad($sformatf("code %h expected %h", got, exp));
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
	endtask

	task automatic chk_lvl(input exc_pkg::level_t got, input exc_pkg::level_t exp);
		tests_run++;
		if (got !== exp) bad($sformatf("level %h expected %h", got, exp));
	endtask

	// one boundary; br: 0 none, 1 uncond, 2 cond not taken, 3 cond taken
	task automatic step(input logic [14:0] yx, input logic wr, input logic rpt, input logic [1:0] br);
		@(posedge mclk);
		boundary <= 1'b1;
		younger_exc <= yx;
		younger_wr <= wr;
		younger_rpt <= rpt;
		id_delayed_uncond <= (br == 2'h1);
		id_delayed_cond <= br[1];
		branch_taken <= (br == 2'h3);
		@(posedge mclk);
		boundary <= 1'b0;
		younger_exc <= 15'h0000;
		{id_delayed_uncond, id_delayed_cond, branch_taken} <= 3'h0;
		#1;
	endtask

	// bounded wait for the acceptance pulse; a hang closes the run
	task automatic take(input exc_pkg::level_t lvl);
		for (int i = 0; i < 8 && accept !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (accept !== 1'b1) begin
			bad("no acceptance");
			complete_run();
		end else begin
			chk_lvl(accept_level, lvl);
		end
	endtask

	task automatic none(input int n);
		repeat (n) begin
			chk_bit(accept, 1'b0);
			@(posedge mclk);
			#1;
		end
	endtask

	task automatic pin_reset(input int k, input logic [11:0] exp);
		@(posedge mclk);
		mem_busy <= (k == 1);
		por_req <= (k == 0);
		manual_reset_req <= (k == 1);
		dbg_reset_req <= (k == 2);
		// look past the launching edge before sampling outputs
		#1;
		if (k == 1) begin
			none(6);
			mem_busy <= 1'b0;
		end
		take(exc_pkg::LVL_RESET);
		chk_bit(reset_taken, 1'b1);
		chk_code(exception_event_reg, exp);
		@(posedge mclk);
		{por_req, manual_reset_req, dbg_reset_req} <= 3'h0;
		repeat (6) @(posedge mclk);
	endtask

	task automatic raise(input logic n, input logic d, input logic e, input logic [3:0] l);
		@(posedge mclk);
		{r_nmi, r_dbg, r_ext} <= {n, d, e};
		r_lvl <= l;
		@(posedge mclk);
		{r_nmi, r_dbg, r_ext} <= 3'h0;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{mclk, por_req, manual_reset_req, dbg_reset_req, boundary, mem_busy, block_mask} = 7'h00;
		{dbg_over_ext, id_delayed_uncond, id_delayed_cond, branch_taken, r_nmi, r_dbg, r_ext} = 7'h00;
		{older_exc, younger_exc, older_wr, older_rpt, younger_wr, younger_rpt} = 34'h0;
		r_lvl = 4'h0;
		rst = 1'b1;
		rows = '{'{15'h0020, 0, 0, 12'h180}, '{15'h0040, 0, 0, 12'h1A0}, '{15'h0080, 0, 0, 12'h160},
			'{15'h0001, 0, 0, 12'h1E0}, '{15'h2000, 0, 0, 12'h1E0}, '{15'h4000, 0, 0, 12'h5C0},
			'{15'h0004, 0, 0, 12'h040}, '{15'h0010, 0, 0, 12'h0A0}, '{15'h0002, 0, 0, 12'h0E0},
			'{15'h0200, 0, 0, 12'h040}, '{15'h0200, 1, 0, 12'h060}, '{15'h0400, 1, 1, 12'h070},
			'{15'h0800, 0, 0, 12'h0A0}, '{15'h0800, 1, 0, 12'h0C0}, '{15'h0800, 0, 1, 12'h0D0},
			'{15'h1000, 1, 0, 12'h080}, '{15'h0100, 0, 0, 12'h0E0}, '{15'h0100, 1, 0, 12'h100},
			'{15'h0100, 0, 1, 12'h070}, '{15'h0021, 0, 0, 12'h1E0}, '{15'h2100, 1, 0, 12'h100}};
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk_code(exception_event_reg, 12'h000);
		chk_code(interrupt_event_reg, 12'h000);
		none(2);
		// every general code, back to back
		foreach (rows[i]) begin
			step(rows[i].exc, rows[i].wr, rows[i].rpt, 2'h0);
			take(exc_pkg::LVL_GENERAL);
			chk_code(exception_event_reg, rows[i].code);
		end
		// reset pins, manual one held off by a memory access
		pin_reset(0, 12'h000);
		pin_reset(1, 12'h020);
		pin_reset(2, 12'h000);
		// every external level, codes on both interrupt registers
		for (lv = 0; lv < 16; lv++) begin
			raise(1'b0, 1'b0, 1'b1, lv[3:0]);
			step(15'h0000, 1'b0, 1'b0, 2'h0);
			take(exc_pkg::LVL_IRQ);
			chk_code(interrupt_event_reg, 12'h200 + 12'(lv * 32));
			chk_code(interrupt_event_reg_alt, 12'h200 + 12'(lv * 32));
		end
		// masked interrupts wait; general exception and then nmi win over ext
		block_mask <= 1'b1;
		raise(1'b1, 1'b0, 1'b1, 4'h5);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		none(3);
		block_mask <= 1'b0;
		older_exc <= 15'h0200;
		older_wr <= 1'b1;
		step(15'h0020, 1'b0, 1'b0, 2'h0);
		older_exc <= 15'h0000;
		take(exc_pkg::LVL_GENERAL);
		chk_code(exception_event_reg, 12'h060);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_NMI);
		chk_code(interrupt_event_reg_alt, 12'h1C0);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_IRQ);
		chk_code(interrupt_event_reg, 12'h2A0);
		// debug against external, order set by software
		dbg_over_ext <= 1'b1;
		raise(1'b0, 1'b1, 1'b1, 4'h1);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_IRQ);
		chk_code(interrupt_event_reg, 12'h5E0);
		dbg_over_ext <= 1'b0;
		raise(1'b0, 1'b1, 1'b0, 4'h1);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_IRQ);
		chk_code(interrupt_event_reg, 12'h220);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_IRQ);
		// slot after unconditional branch: retry type taken ahead of the branch
		step(15'h0000, 1'b0, 1'b0, 2'h1);
		step(15'h0004, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_GENERAL);
		chk_bit(retry_from_branch, 1'b1);
		chk_code(exception_event_reg, 12'h040);
		// completion type and interrupt held over the slot boundary
		// raised after the branch boundary, else it is taken ahead of the branch
		step(15'h0000, 1'b0, 1'b0, 2'h1);
		raise(1'b0, 1'b0, 1'b1, 4'h2);
		step(15'h0080, 1'b0, 1'b0, 2'h0);
		none(3);
		step(15'h0000, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_IRQ);
		chk_code(interrupt_event_reg, 12'h240);
		// conditional branch: slot only when taken
		step(15'h0000, 1'b0, 1'b0, 2'h2);
		step(15'h0004, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_GENERAL);
		chk_bit(retry_from_branch, 1'b0);
		step(15'h0000, 1'b0, 1'b0, 2'h3);
		step(15'h0020, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_GENERAL);
		chk_bit(retry_from_branch, 1'b1);
		chk_code(exception_event_reg, 12'h180);
		// second reset in mid-run clears the event registers
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		#1;
		chk_code(exception_event_reg, 12'h000);
		chk_code(interrupt_event_reg_alt, 12'h000);
		none(1);
		// first request after the mid-run reset
		step(15'h0080, 1'b0, 1'b0, 2'h0);
		take(exc_pkg::LVL_GENERAL);
		chk_code(exception_event_reg, 12'h160);
		complete_run();
	end

	// watchdog against a hang outside the bounded waits
	initial begin
		#500000;
		bad("watchdog expired");
		complete_run();
	end

endmodule // exception_priority_code_unit_test
`default_nettype wire
